// [design/hdpm_port_manager.sv]
/*
 * downstream port manager of a four-port full-speed hub repeater:
 * attach detection, speed and enable registers, babble shut-off,
 * traffic gating and forced line states, behind a wishbone slave.
 * assumes line and frame inputs synchronous to sys_clk_i (40 MHz),
 * and a master that holds each request until ack.
 */
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`include "hdpm_params.svh"

module hdpm_port_manager
    import hdpm_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // hub state
    input wire logic bus_reset_i,
    input wire logic suspended_i,
    input wire logic hub_irq_en_i,
    // frame and traffic
    input wire logic up_active_i,
    input wire logic up_fs_i,
    input wire logic eof1_i,
    input wire logic eof2_i,
    input wire logic [3:0] down_active_i,
    // downstream lines
    input wire hdpm_lines_s lines_i,
    output hdpm_drive_s drive_o,
    output logic [3:0] slew_ls_o,
    // repeater steering and events
    output logic [3:0] port_rx_en_o,
    output logic [3:0] port_tx_en_o,
    output logic eop_gen_o,
    output logic hub_irq_o
);

    // ---------------------------------------------------------------
    // constants
    // ---------------------------------------------------------------
    localparam logic [CNT_W-1:0] CONN_CYC = CNT_W'(`HDPM_CONN_CYC);
    localparam logic [CNT_W-1:0] DISC_CYC = CNT_W'(`HDPM_DISC_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    function automatic logic [1:0] fld(input logic [7:0] v, input int p);
        fld = v[2*p +: 2];
    endfunction

    function automatic logic wb_hit(input logic [4:0] a,
                                    input logic [4:0] ofs);
        wb_hit = (a[4:2] == ofs[4:2]);
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [3:0] attach_q;
    logic [3:0] speed_q;
    logic [3:0] enable_q;
    logic [3:0] pend_q;
    logic [3:0] conn_q;
    logic [7:0] force_q;
    logic [3:0] se0_q;
    logic [3:0] se0_prev_q;
    logic [CNT_W-1:0] cnt_q [4];
    logic [3:0] att_set;
    logic [3:0] att_clr;
    logic [3:0] babble;
    logic wr_req;
    logic clr_all;

    assign wr_req = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign clr_all = rst_i || bus_reset_i;

    // ---------------------------------------------------------------
    // wishbone handshake and read data
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_o && !we_i) begin
            // reserved bits read zero: 4-31, or 8-31 for the force register
            if (wb_hit(adr_i, `HDPM_OFS_ATTACH)) begin
                dat_o <= {28'h0, attach_q};
            end else if (wb_hit(adr_i, `HDPM_OFS_SPEED)) begin
                dat_o <= {28'h0, speed_q};
            end else if (wb_hit(adr_i, `HDPM_OFS_ENABLE)) begin
                dat_o <= {28'h0, enable_q};
            end else if (wb_hit(adr_i, `HDPM_OFS_FORCE)) begin
                dat_o <= {24'h0, force_q};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // ---------------------------------------------------------------
    // line sampling and persistence counters
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            se0_q <= 4'hf;
            se0_prev_q <= 4'hf;
        end else begin
            // both lines low reads as no device
            se0_q <= ~(lines_i.dp | lines_i.dm);
            se0_prev_q <= se0_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 4; p++) begin
            if (clr_all || se0_q[p] != se0_prev_q[p]
                    || fld(force_q, p) != `HDPM_FORCE_NONE) begin
                cnt_q[p] <= '0;
            end else if (cnt_q[p] != CNT_MAX) begin
                cnt_q[p] <= cnt_q[p] + CNT_W'(1);
            end
        end
    end

    always_comb begin
        for (int p = 0; p < 4; p++) begin
            // j or k held past 2.5 us
            // both samples must agree: the counter lags the line by one
            att_set[p] = !attach_q[p] && !se0_q[p] && !se0_prev_q[p]
                && cnt_q[p] >= CONN_CYC;
            // se0 held 2.0 us
            att_clr[p] = attach_q[p] && se0_q[p] && se0_prev_q[p]
                && cnt_q[p] >= DISC_CYC - CNT_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // attach flags, bits 0-3 for ports 1-4
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr_all) begin
            attach_q <= `HDPM_PORT_RST;
        end else begin
            // hardware events win over a firmware write
            if (wr_req && wb_hit(adr_i, `HDPM_OFS_ATTACH)) begin
                attach_q <= (dat_i[3:0] | att_set) & ~att_clr;
            end else begin
                attach_q <= (attach_q | att_set) & ~att_clr;
            end
        end
    end

    // ---------------------------------------------------------------
    // hub interrupt, also while suspended
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hub_irq_o <= 1'b0;
        end else begin
            // raised regardless of port enable or suspend; hub_irq_en_i masks it
            hub_irq_o <= hub_irq_en_i && |(att_set | att_clr);
        end
    end

    // ---------------------------------------------------------------
    // speed select and force fields
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr_all) begin
            speed_q <= `HDPM_PORT_RST;
        end else if (wr_req && wb_hit(adr_i, `HDPM_OFS_SPEED)) begin
            speed_q <= dat_i[3:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        // only chip reset clears them
        if (rst_i) begin
            force_q <= `HDPM_FORCE_RST;
        end else if (wr_req && wb_hit(adr_i, `HDPM_OFS_FORCE)) begin
            force_q <= dat_i[7:0];
        end
    end

    // ---------------------------------------------------------------
    // babble: upstream connectivity and traffic at EOF2
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr_all) begin
            conn_q <= 4'h0;
        end else begin
            conn_q <= (conn_q | (enable_q & down_active_i))
                & down_active_i & enable_q;
        end
    end

    assign babble = eof2_i ? (enable_q & (down_active_i | conn_q)) : 4'h0;

    // ---------------------------------------------------------------
    // enables, deferred to the end of a packet
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr_all) begin
            enable_q <= `HDPM_PORT_RST;
            pend_q <= `HDPM_PORT_RST;
        end else if (wr_req && wb_hit(adr_i, `HDPM_OFS_ENABLE)) begin
            // disables act at once; enables wait for idle
            if (up_active_i) begin
                enable_q <= enable_q & dat_i[3:0] & ~babble;
                pend_q <= dat_i[3:0] & ~enable_q;
            end else begin
                enable_q <= dat_i[3:0] & ~babble;
                pend_q <= 4'h0;
            end
        end else begin
            if (!up_active_i) begin
                enable_q <= (enable_q | pend_q) & ~babble;
                pend_q <= 4'h0;
            end else begin
                enable_q <= enable_q & ~babble;
            end
        end
    end

    // ---------------------------------------------------------------
    // repeater steering, EOP at EOF1, forced lines
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            port_rx_en_o <= 4'h0;
            port_tx_en_o <= 4'h0;
            eop_gen_o <= 1'b0;
            slew_ls_o <= 4'h0;
        end else begin
            port_rx_en_o <= enable_q & ~(speed_q & {4{up_fs_i}});
            port_tx_en_o <= enable_q & ~babble;
            eop_gen_o <= eof1_i;
            slew_ls_o <= speed_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            drive_o <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                drive_o.oe[p] <= fld(force_q, p) != `HDPM_FORCE_NONE;
                drive_o.dp[p] <= fld(force_q, p) == `HDPM_FORCE_DIFF1;
                drive_o.dm[p] <= fld(force_q, p) == `HDPM_FORCE_DIFF0;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // line class run length, kept apart from the detect counters
    logic [CNT_W-1:0] run_q [4];

    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 4; p++) begin
            if (clr_all || (lines_i.dp[p] | lines_i.dm[p]) == se0_q[p]) begin
                run_q[p] <= '0;
            end else if (run_q[p] != CNT_MAX) begin
                run_q[p] <= run_q[p] + CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_conn_timing: assert property (
        $rose(attach_q[0])
        && !$past(wr_req && wb_hit(adr_i, `HDPM_OFS_ATTACH))
        |-> !se0_q[0] && run_q[0] >= CONN_CYC)
        else $error("connect recorded too early");

    a_disc_clear: assert property (
        attach_q[1] && se0_q[1] && run_q[1] >= DISC_CYC && !clr_all
        && fld(force_q, 1) == `HDPM_FORCE_NONE
        |=> !attach_q[1])
        else $error("disconnect not recorded");

    a_disc_early: assert property (
        $fell(attach_q[1]) && !$past(clr_all)
        && !$past(wr_req && wb_hit(adr_i, `HDPM_OFS_ATTACH))
        |-> se0_q[1] && run_q[1] >= DISC_CYC - CNT_W'(1))
        else $error("disconnect recorded too early");

    a_irq_event: assert property (
        hub_irq_en_i && |(att_set | att_clr) |=> hub_irq_o)
        else $error("hub interrupt missing");

    a_irq_cause: assert property (
        hub_irq_o |-> $past(hub_irq_en_i)
        && ($past(attach_q) != attach_q || $past(clr_all)))
        else $error("hub interrupt without attach change");

    a_busrst_clear: assert property (
        bus_reset_i |=> enable_q == 4'h0 && speed_q == 4'h0
        && attach_q == 4'h0)
        else $error("bus reset left state set");

    a_force_keep: assert property (
        bus_reset_i && !wr_req |=> $stable(force_q))
        else $error("force field cleared by bus reset");

    a_babble_off: assert property (
        |babble |=> (enable_q & $past(babble)) == 4'h0)
        else $error("babble did not disable port");

    a_enable_wait: assert property (
        up_active_i && !eof2_i && !(wr_req
            && wb_hit(adr_i, `HDPM_OFS_ENABLE))
        |=> (enable_q & ~$past(enable_q)) == 4'h0)
        else $error("enable took effect mid packet");

    a_ls_block: assert property (
        up_fs_i |=> (port_rx_en_o & $past(speed_q)) == 4'h0)
        else $error("full speed repeated to low speed port");

    a_eop_eof1: assert property (
        eof1_i |=> eop_gen_o)
        else $error("no EOP at EOF1");

    a_force_se0: assert property (
        fld(force_q, 3) == `HDPM_FORCE_SE0 |=> drive_o.oe[3]
        && !drive_o.dp[3] && !drive_o.dm[3])
        else $error("SE0 force drives wrong lines");

    c_connect: cover property ($rose(attach_q[0]));
    c_disconnect: cover property ($fell(attach_q[0]) && !$past(bus_reset_i));
    c_babble: cover property (|babble);
    c_deferred: cover property (|pend_q ##1 !up_active_i);
    c_susp_event: cover property (suspended_i && |att_clr);

endmodule

// [include/hdpm_params.svh]
/*
 * constants of the downstream port manager: register offsets, reset
 * values, force codes and timing figures.
 * assumes a 40 MHz system clock and byte addresses on the register bus.
 */
`ifndef HDPM_PARAMS_SVH
`define HDPM_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define HDPM_OFS_ATTACH 5'h00
`define HDPM_OFS_SPEED 5'h04
`define HDPM_OFS_ENABLE 5'h08
`define HDPM_OFS_FORCE 5'h0c

// ---------------------------------------------------------------
// reset values and field layout
// ---------------------------------------------------------------
`define HDPM_PORT_RST 4'h0
`define HDPM_FORCE_RST 8'h00
`define HDPM_FORCE_NONE 2'h0
`define HDPM_FORCE_DIFF1 2'h1
`define HDPM_FORCE_DIFF0 2'h2
`define HDPM_FORCE_SE0 2'h3

// ---------------------------------------------------------------
// timing, in ns, and counts derived from the clock period
// ---------------------------------------------------------------
`define HDPM_CLK_NS 25
`define HDPM_CONN_NS 2500
`define HDPM_DISC_NS 2000
`define HDPM_CONN_CYC ((`HDPM_CONN_NS + `HDPM_CLK_NS - 1) / `HDPM_CLK_NS)
`define HDPM_DISC_CYC ((`HDPM_DISC_NS + `HDPM_CLK_NS - 1) / `HDPM_CLK_NS)

`endif

// [include/hdpm_pkg.sv]
/*
 * types of the downstream port manager.
 * assumes four downstream ports, one bit each per vector.
 */
package hdpm_pkg;

    // ---------------------------------------------------------------
    // line sample and line drive of all ports
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [3:0] dp;
        logic [3:0] dm;
    } hdpm_lines_s;

    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] dp;
        logic [3:0] dm;
    } hdpm_drive_s;

endpackage

// [tb/hdpm_port_manager_tb.sv]
/*
 * self-checking bench of the downstream port manager.
 * assumes the device model in hdpm_usb_dev_model.
 */
`timescale 1ns/100ps
module hdpm_port_manager_tb
    import hdpm_pkg::*;
;
    typedef struct {
        logic we;
        logic [4:0] adr;
        logic [31:0] wd;
        logic [31:0] exp;
    } hdpm_row_s;
    logic sys_clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0, stb = 0, we = 0, bus_rst = 0, susp = 0, irq_en = 1;
    logic up_act = 0, up_fs = 0, eof1 = 0, eof2 = 0;
    logic [4:0] adr = 0;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic [3:0] down_act = 0, att = 0, ls = 0, slew, rxen, txen;
    logic ack_o, eop, irq;
    hdpm_lines_s lines;
    hdpm_drive_s drv;
    int n_fail = 0, checked = 0, n;
    hdpm_row_s rows[9] = '{
        '{1'b0, 5'h00, 32'h0, 32'h0}, '{1'b0, 5'h04, 32'h0, 32'h0},
        '{1'b0, 5'h08, 32'h0, 32'h0}, '{1'b0, 5'h0c, 32'h0, 32'h0},
        '{1'b1, 5'h04, 32'hf5, 32'h05}, '{1'b1, 5'h0c, 32'he4, 32'he4},
        '{1'b1, 5'h10, 32'hff, 32'h0}, '{1'b1, 5'h0c, 32'h0, 32'h0},
        '{1'b1, 5'h04, 32'h0, 32'h0}};

    always #12.5 sys_clk_i = ~sys_clk_i;

    hdpm_port_manager DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
        .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .bus_reset_i(bus_rst),
        .suspended_i(susp), .hub_irq_en_i(irq_en), .up_active_i(up_act),
        .up_fs_i(up_fs), .eof1_i(eof1), .eof2_i(eof2),
        .down_active_i(down_act), .lines_i(lines), .drive_o(drv),
        .slew_ls_o(slew), .port_rx_en_o(rxen), .port_tx_en_o(txen),
        .eop_gen_o(eop), .hub_irq_o(irq));

    hdpm_usb_dev_model dev (.attach_i(att), .low_speed_i(ls),
        .drive_i(drv), .lines_o(lines));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask
    // classic cycle, held until ack, then one idle cycle
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
        if (k == 20) begin
            n_fail++;
            tally_and_finish();
        end
        @(posedge sys_clk_i);
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, rdat, e);
    endtask
    // edges from the call until the interrupt pulse is seen
    task wait_irq(output int c);
        c = 0;
        do begin
            @(posedge sys_clk_i);
            c++;
        end while (irq !== 1'b1 && c < 300);
        if (c == 300) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(4);
        rst_i <= 0;
        tick(1);
        foreach (rows[i]) begin
            if (rows[i].we)
                wb(1'b1, rows[i].adr, rows[i].wd);
            rd(rows[i].adr, rows[i].exp, $sformatf("row %0d", i));
        end
        // full speed on port 1, low speed on port 2; 100 cycles is 2.5 us
        att <= 4'h3;
        ls <= 4'h2;
        wait_irq(n);
        chk("connect delay", 32'(n > 101 && n < 111), 32'h1);
        rd(5'h00, 32'h3, "attach");
        // disconnect while suspended on a disabled port; 80 cycles is 2 us
        susp <= 1;
        att <= 4'h1;
        wait_irq(n);
        chk("detach delay", 32'(n > 80 && n < 102), 32'h1);
        susp <= 0;
        rd(5'h00, 32'h1, "detach");
        wb(1'b1, 5'h04, 32'h2);
        wb(1'b1, 5'h08, 32'h3);
        up_fs <= 1;
        tick(3);
        chk("rx fs", rxen, 32'h1);
        chk("tx", txen, 32'h3);
        up_fs <= 0;
        tick(3);
        chk("rx ls", rxen, 32'h3);
        up_act <= 1;
        wb(1'b1, 5'h08, 32'h7);
        tick(3);
        chk("rx busy", rxen, 32'h3);
        up_act <= 0;
        tick(3);
        chk("rx idle", rxen, 32'h7);
        down_act <= 4'h1;
        eof2 <= 1;
        tick(1);
        eof2 <= 0;
        down_act <= 4'h0;
        tick(3);
        rd(5'h08, 32'h6, "babble");
        chk("tx babble", txen, 32'h6);
        eof1 <= 1;
        tick(1);
        eof1 <= 0;
        tick(1);
        chk("eop", eop, 32'h1);
        // port 4 is disabled while forced
        for (int c = 1; c < 4; c++) begin
            wb(1'b1, 5'h0c, 32'(c << 6));
            tick(2);
            chk("force", {drv.oe[3], drv.dp[3], drv.dm[3]},
                {1'b1, c == 1, c == 2});
        end
        chk("slew", slew, 32'h2);
        bus_rst <= 1;
        tick(1);
        bus_rst <= 0;
        tick(2);
        rd(5'h00, 32'h0, "busrst attach");
        rd(5'h04, 32'h0, "busrst speed");
        rd(5'h08, 32'h0, "busrst enable");
        rd(5'h0c, 32'hc0, "busrst force");
        // port 1 reattaches after the bus reset, interrupt masked
        irq_en <= 0;
        n = 0;
        repeat (150) begin
            @(posedge sys_clk_i);
            n += irq;
        end
        chk("irq masked", n, 32'h0);
        rd(5'h00, 32'h1, "reattach");
        rst_i <= 1;
        tick(2);
        rst_i <= 0;
        tick(1);
        rd(5'h0c, 32'h0, "rst force");
        chk("rst drive", drv, 32'h0);
        tally_and_finish();
    end
endmodule

// [tb/hdpm_usb_dev_model.sv]
/*
 * behavioural model of the four devices on the downstream ports.
 * assumes the hub drive wins while its enable is high.
 */
`timescale 1ns/100ps
module hdpm_usb_dev_model
    import hdpm_pkg::*;
(
    // device presence and speed per port
    input wire logic [3:0] attach_i,
    input wire logic [3:0] low_speed_i,
    // hub side of the lines
    input wire hdpm_drive_s drive_i,
    output hdpm_lines_s lines_o
);
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            if (drive_i.oe[p]) begin
                lines_o.dp[p] = drive_i.dp[p];
                lines_o.dm[p] = drive_i.dm[p];
            end else begin
                // pull-downs leave an empty port at both low
                lines_o.dp[p] = attach_i[p] & ~low_speed_i[p];
                lines_o.dm[p] = attach_i[p] & low_speed_i[p];
            end
        end
    end
endmodule
